/* File: verilog/rx_int_ack_vector_logic.sv */
// receive interrupt, acknowledge and vector logic of a two-channel serial controller
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module rx_int_ack_vector_logic
  import rx_int_ack_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic     clk,
  input  wire logic     srst,
  // register port
  input  wire reg_req_t req,
  output logic [7:0]    rdata,
  // receivers, one per channel (index 1 = channel a)
  input  wire rx_char_t rx_in [2],
  input  wire logic     tx_empty [2],
  input  wire logic     ext_change [2],
  // acknowledge and daisy chain pins
  input  wire logic     int_ack_n,
  input  wire logic     chain_in,
  output logic          int_req_n,
  output logic          chain_out,
  output logic [7:0]    vec_out,
  output logic          vec_oe
);

  localparam int AW = $clog2(FIFO_DEPTH);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] ack_s, chi_s;
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_s <= 2'h3;
      chi_s <= 2'h3;
    end else begin
      ack_s <= {ack_s[0], int_ack_n};
      chi_s <= {chi_s[0], chain_in};
    end
  end
  logic ack_q;
  always_ff @(posedge clk) begin
    if (srst) ack_q <= 1'b0;
    else ack_q <= ~ack_s[1];
  end
  logic ack_act;
  assign ack_act = ~ack_s[1];

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0] master_int_ctrl_reg, vector_base;
  logic [7:0] int_enable_reg [2];
  logic [7:0] extended_feature_reg [2];
  logic       wr_cmd;
  logic [2:0] cmd_code;
  assign wr_cmd   = req.wr && req.addr == OFS_COMMAND;
  assign cmd_code = req.wdata[5:3];

  always_ff @(posedge clk) begin
    if (srst) begin
      master_int_ctrl_reg <= RST_MASTER_CTRL;
      vector_base         <= RST_VECTOR_BASE;
    end else if (req.wr) begin
      if (req.addr == OFS_MASTER_CTRL) master_int_ctrl_reg <= req.wdata;
      if (req.addr == OFS_VECTOR) vector_base <= req.wdata;
    end
  end

  logic sw_ack_mode, global_int_enable, vector_status_include, no_vector_bit;
  assign sw_ack_mode           = master_int_ctrl_reg[MIC_SWACK];
  assign global_int_enable     = master_int_ctrl_reg[MIC_MIE];
  assign vector_status_include = master_int_ctrl_reg[MIC_VIS] & ~sw_ack_mode;
  assign no_vector_bit         = master_int_ctrl_reg[MIC_NV] & ~sw_ack_mode;

  // ****************************************************************
  // per channel receive fifo and pending bits
  // ****************************************************************
  // src order, low to high priority: b tx, b ext, b rx; a tx, a ext, a rx
  logic [NSRC-1:0] pending_bit;
  logic [NSRC-1:0] under_service_bit;
  logic            special [2];
  logic [7:0]      rx_top  [2];
  logic [3:0]      err_top [2];
  logic [AW:0]     rx_count [2];
  logic            rx_pop  [2];
  logic            reset_ius;
  logic            soft_ack;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [11:0] mem [FIFO_DEPTH];
      logic [AW-1:0] rp, wp;
      logic [AW:0]   cnt;
      logic          lock, first_armed;
      logic [1:0]    mode;
      logic          par_sp, thr, sp_exit, sp_any4, chr_irq, sp_irq;
      logic          sel_wr;

      assign sel_wr = req.wr && (req.chan_a == 1'(ch));
      always_ff @(posedge clk) begin
        if (srst) begin
          int_enable_reg[ch]       <= RST_INT_ENABLE;
          extended_feature_reg[ch] <= RST_EXT_FEATURE;
        end else if (sel_wr) begin
          if (req.addr == OFS_INT_ENABLE) int_enable_reg[ch] <= req.wdata;
          if (req.addr == OFS_EXT_FEATURE) extended_feature_reg[ch] <= req.wdata;
        end
      end
      assign mode   = int_enable_reg[ch][IE_MODE_L+1:IE_MODE_L];
      assign par_sp = int_enable_reg[ch][IE_PAR];
      assign thr    = extended_feature_reg[ch][EF_THRESH];

      // data and error live in one entry so one read pops both
      assign rx_pop[ch] = req.rd && req.addr == OFS_RX_DATA && req.chan_a == 1'(ch)
                          && cnt != '0 && !lock;
      always_ff @(posedge clk) begin
        if (srst) begin
          rp  <= '0;
          wp  <= '0;
          cnt <= '0;
        end else begin
          if (rx_in[ch].valid && cnt != (AW+1)'(FIFO_DEPTH)) begin
            mem[wp] <= {rx_in[ch].data, rx_in[ch].err};
            wp      <= wp + 1'b1;
          end
          if (rx_pop[ch]) rp <= rp + 1'b1;
          cnt <= cnt + (AW+1)'(rx_in[ch].valid && cnt != (AW+1)'(FIFO_DEPTH))
                     - (AW+1)'(rx_pop[ch]);
        end
      end
      assign rx_count[ch] = cnt;
      assign rx_top[ch]   = mem[rp][11:4];
      assign err_top[ch]  = mem[rp][3:0];

      function automatic logic is_sp(input logic [3:0] e);
        is_sp = e[ERR_OVR-4] | e[ERR_FRM-4] | e[ERR_EOF-4] | (par_sp & e[ERR_PAR-4]);
      endfunction
      assign sp_exit = cnt != '0 && is_sp(err_top[ch]);
      always_comb begin
        sp_any4 = 1'b0;
        for (int i = 0; i < THRESH_BYTES; i++)
          if (AW'(i) < cnt[AW-1:0] || cnt[AW])
            sp_any4 |= is_sp(mem[rp + AW'(i)][3:0]);
      end

      // special condition locks the exit slot until error reset, except in threshold mode or in the all-characters mode
      always_ff @(posedge clk) begin
        if (srst) lock <= 1'b0;
        // a fresh lock beats an error reset in the same cycle, so no status is lost
        else if (rx_pop[ch] && is_sp(err_top[ch]) && !thr && mode != RXM_ALL) lock <= 1'b1;
        else if (sel_wr && wr_cmd && cmd_code == CMD_ERR_RESET) lock <= 1'b0;
      end
      always_ff @(posedge clk) begin
        if (srst) first_armed <= 1'b1;
        else if (sel_wr && wr_cmd && cmd_code == CMD_NEXT_RX) first_armed <= 1'b1;
        else if (mode == RXM_FIRST && rx_pop[ch]) first_armed <= 1'b0;
      end

      always_comb begin
        chr_irq = 1'b0;
        sp_irq  = 1'b0;
        case (mode)
          RXM_FIRST: begin
            chr_irq = first_armed && cnt != '0;
            sp_irq  = lock;
          end
          RXM_ALL: begin
            chr_irq = thr ? cnt >= (AW+1)'(THRESH_BYTES) : cnt != '0;
            sp_irq  = thr ? sp_any4 : sp_exit;
          end
          RXM_SPECIAL: sp_irq = lock;
          default: ;
        endcase
      end
      assign special[ch] = sp_irq;

      // pending bits follow their conditions, so removal clears them
      always_ff @(posedge clk) begin
        if (srst) pending_bit[3*ch +: 3] <= '0;
        else pending_bit[3*ch +: 3] <= {chr_irq | sp_irq,
                                        ext_change[ch] & int_enable_reg[ch][IE_EXT],
                                        tx_empty[ch] & int_enable_reg[ch][IE_TX]};
      end
    end
  endgenerate

  // ****************************************************************
  // priority, under-service and acknowledge
  // ****************************************************************
  logic [NSRC-1:0] grant;
  logic [NSRC-1:0] ius_high;
  logic            any_grant;
  always_comb begin
    grant = '0;
    any_grant = 1'b0;
    for (int i = NSRC-1; i >= 0; i--) begin
      if (!any_grant && under_service_bit[i]) any_grant = 1'b1;  // masks lower ones
      else if (!any_grant && pending_bit[i]) begin
        grant[i]  = 1'b1;
        any_grant = 1'b1;
      end
    end
  end
  always_comb begin
    ius_high = '0;
    for (int i = NSRC-1; i >= 0; i--)
      if (under_service_bit[i] && ius_high == '0) ius_high[i] = 1'b1;
  end

  logic read_vec;
  assign read_vec  = req.rd && req.addr == OFS_VECTOR;
  assign soft_ack  = read_vec && sw_ack_mode && chi_s[1];
  assign reset_ius = wr_cmd && cmd_code == CMD_RESET_IUS;
  logic hard_ack;
  assign hard_ack = ack_act && !ack_q && chi_s[1];

  always_ff @(posedge clk) begin
    if (srst) under_service_bit <= '0;
    else if (hard_ack || soft_ack) under_service_bit <= under_service_bit | grant;
    else if (reset_ius) under_service_bit <= under_service_bit & ~ius_high;
  end

  // ****************************************************************
  // vector build
  // ****************************************************************
  function automatic logic [2:0] src_code(input logic [NSRC-1:0] g);
    logic [2:0] c;
    c = 3'h3;  // nothing pending reads as channel b special
    for (int i = 0; i < NSRC; i++)
      if (g[i]) c = {i >= 3, (i % 3 == 2), (i % 3 == 1)};
    if ((g[2] && special[0]) || (g[5] && special[1])) c[0] = 1'b1;
    return c;
  endfunction
  function automatic logic [7:0] put_status(input logic [7:0] v, input logic [2:0] c);
    logic [7:0] r;
    r = v;
    if (master_int_ctrl_reg[MIC_SHSL]) r[6:4] = {c[0], c[1], c[2]};
    else r[3:1] = c;
    return r;
  endfunction

  // status names the highest pending source not below one in service, even one already in service
  logic [NSRC-1:0] top_pend;
  logic            top_hit;
  always_comb begin
    top_pend = '0;
    top_hit  = 1'b0;
    for (int i = NSRC-1; i >= 0; i--) begin
      if (!top_hit && pending_bit[i]) begin
        top_pend[i] = 1'b1;
        top_hit     = 1'b1;
      end else if (under_service_bit[i]) top_hit = 1'b1;
    end
  end

  logic [NSRC-1:0] shown;
  assign shown = (no_vector_bit && under_service_bit != '0) ? ius_high : top_pend;
  logic [7:0] vec_mod;
  assign vec_mod = put_status(vector_base, src_code(shown));

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic irq;
  assign irq = global_int_enable && chi_s[1] && grant != '0 && !ack_act;
  always_ff @(posedge clk) begin
    if (srst) int_req_n <= 1'b1;
    else int_req_n <= ~irq | soft_ack;
  end
  always_ff @(posedge clk) begin
    if (srst) chain_out <= 1'b0;
    else chain_out <= chi_s[1] && under_service_bit == '0 && !soft_ack
                      && !(ack_act && pending_bit != '0);
  end
  // vector captured once per acknowledge and held stable on the bus
  always_ff @(posedge clk) begin
    if (srst) begin
      vec_out <= 8'h00;
      vec_oe  <= 1'b0;
    end else begin
      vec_oe <= ack_act && !no_vector_bit && (any_grant || ack_q) && chi_s[1];
      if (hard_ack) vec_out <= vector_status_include ? vec_mod : vector_base;
    end
  end

  // read data is sampled in one edge, so a new interrupt mid-read cannot tear it
  always_ff @(posedge clk) begin
    if (srst) rdata <= 8'h00;
    else if (req.rd) begin
      case (req.addr)
        OFS_VECTOR: rdata <= (req.chan_a && (sw_ack_mode || !vector_status_include))
                             ? vector_base : vec_mod;
        OFS_PENDING: rdata <= req.chan_a ? {2'h0, pending_bit[5], pending_bit[3],
                              pending_bit[4], pending_bit[2], pending_bit[0],
                              pending_bit[1]} : 8'h00;
        OFS_MAIN_STATUS: rdata <= {7'h00, rx_count[req.chan_a] != '0};
        OFS_RX_ERROR: rdata <= {err_top[req.chan_a], 4'h0};
        OFS_RX_DATA: rdata <= rx_top[req.chan_a];
        default: rdata <= 8'h00;
      endcase
    end else rdata <= 8'h00;
  end

endmodule

/* File: verilog/rx_int_ack_pkg.sv */
// constants and types shared by the receive interrupt and acknowledge logic
package rx_int_ack_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [3:0] OFS_COMMAND      = 4'h0;
  localparam logic [3:0] OFS_INT_ENABLE   = 4'h1;
  localparam logic [3:0] OFS_VECTOR       = 4'h2;
  localparam logic [3:0] OFS_PENDING      = 4'h3;
  localparam logic [3:0] OFS_MASTER_CTRL  = 4'h9;
  localparam logic [3:0] OFS_EXT_FEATURE  = 4'h7;
  localparam logic [3:0] OFS_MAIN_STATUS  = 4'h0;
  localparam logic [3:0] OFS_RX_ERROR     = 4'h1;
  localparam logic [3:0] OFS_RX_DATA      = 4'h8;

  // ****************************************************************
  // field positions and codes
  // ****************************************************************
  localparam int MIC_VIS   = 0;
  localparam int MIC_NV    = 1;
  localparam int MIC_MIE   = 3;
  localparam int MIC_SHSL  = 4;
  localparam int MIC_SWACK = 5;
  localparam int IE_EXT    = 0;
  localparam int IE_TX     = 1;
  localparam int IE_PAR    = 2;
  localparam int IE_MODE_L = 3;
  localparam int EF_THRESH = 3;
  localparam int ERR_PAR   = 4;
  localparam int ERR_OVR   = 5;
  localparam int ERR_FRM   = 6;
  localparam int ERR_EOF   = 7;
  localparam logic [2:0] CMD_RESET_IUS  = 3'h7;
  localparam logic [2:0] CMD_ERR_RESET  = 3'h6;
  localparam logic [2:0] CMD_NEXT_RX    = 3'h4;
  localparam logic [1:0] RXM_OFF        = 2'h0;
  localparam logic [1:0] RXM_FIRST      = 2'h1;
  localparam logic [1:0] RXM_ALL        = 2'h2;
  localparam logic [1:0] RXM_SPECIAL    = 2'h3;
  localparam int NSRC = 6;
  localparam int THRESH_BYTES = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_MASTER_CTRL = 8'h00;
  localparam logic [7:0] RST_INT_ENABLE  = 8'h00;
  localparam logic [7:0] RST_EXT_FEATURE = 8'h00;
  localparam logic [7:0] RST_VECTOR_BASE = 8'h00;

  // register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       chan_a;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // received character with its error bits
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [3:0] err;
  } rx_char_t;

endpackage

/* File: bench/rx_int_ack_monitor.sv */
// assertion checker for the receive interrupt and acknowledge ports
`timescale 1ns/100ps
module rx_int_ack_monitor
  import rx_int_ack_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // register port
  input wire reg_req_t   req,
  input wire logic [7:0] rdata,
  // acknowledge and chain pins
  input wire logic       int_ack_n,
  input wire logic       int_req_n,
  input wire logic       chain_out,
  input wire logic [7:0] vec_out,
  input wire logic       vec_oe
);
  default clocking cb @(posedge clk); endclocking
  // ****************************************************************
  // shadow of the master control bits, tracked from the write strobes
  // ****************************************************************
  logic mie_q;
  logic nv_q;
  logic swack_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      mie_q   <= 1'b0;
      nv_q    <= 1'b0;
      swack_q <= 1'b0;
    end else if (req.wr && req.addr == OFS_MASTER_CTRL) begin
      mie_q   <= req.wdata[MIC_MIE];
      nv_q    <= req.wdata[MIC_NV];
      swack_q <= req.wdata[MIC_SWACK];
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  sequence soft_ack_s;
    req.rd && req.addr == OFS_VECTOR && swack_q && !int_req_n;
  endsequence
  sequence ack_done_s;
    ##[1:4] (int_req_n && !chain_out);
  endsequence
  a_reset_quiet: assert property (srst |=> (int_req_n && !vec_oe && !chain_out && rdata == 8'h00))
    else $error("outputs not quiet after reset");
  a_rdata_idle: assert property (disable iff (srst) !$past(req.rd) |-> rdata == 8'h00)
    else $error("read data outside the read answer cycle");
  // request may lag a cleared enable by the int_req_n output register
  a_req_needs_mie: assert property (disable iff (srst)
    $fell(int_req_n) |-> (mie_q || $past(mie_q) || $past(mie_q, 2)))
    else $error("request raised without global enable");
  a_nv_no_drive: assert property (disable iff (srst) $rose(vec_oe) |-> !$past(nv_q))
    else $error("vector driven with no-vector set");
  a_vec_held: assert property (disable iff (srst) vec_oe && $past(vec_oe) |-> $stable(vec_out))
    else $error("vector changed while driven");
  a_oe_in_ack: assert property (disable iff (srst) $rose(vec_oe) |-> !int_ack_n)
    else $error("vector driven outside acknowledge");
  a_soft_ack_done: assert property (disable iff (srst) soft_ack_s |-> ack_done_s)
    else $error("software acknowledge left request or chain");
  a_pend_b_zero: assert property (disable iff (srst)
    req.rd && !req.chan_a && req.addr == OFS_PENDING |=> rdata == 8'h00)
    else $error("pending status read on channel b not zero");
endmodule

/* File: bench/host_ack_model.sv */
// host side model: answers an interrupt request with an acknowledge pulse
`timescale 1ns/100ps
module host_ack_model (
  // clock
  input wire logic       clk,
  // control from the bench
  input wire logic       ack_en,
  input wire logic [3:0] settle,
  // device pins
  input wire logic       int_req_n,
  output logic           int_ack_n,
  output logic           chain_in
);
  // head of the chain: nothing above ever holds this device off
  assign chain_in = 1'b1;
  initial begin
    int_ack_n = 1'b1;
    forever begin
      @(posedge clk);
      if (ack_en && !int_req_n) begin
        repeat (settle) @(posedge clk);
        int_ack_n <= 1'b0;
        repeat (8) @(posedge clk);
        int_ack_n <= 1'b1;
        repeat (2) @(posedge clk);
      end
    end
  end
endmodule

/* File: bench/rx_int_ack_vector_logic_tb_top.sv */
// self-checking bench for the receive interrupt and acknowledge logic
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module rx_int_ack_vector_logic_tb_top;
  import rx_int_ack_pkg::*;
  logic        clk;
  logic        srst;
  reg_req_t    req;
  logic [7:0]  rdata;
  rx_char_t    rx_in [2];
  logic        tx_empty [2];
  logic        ext_change [2];
  logic        int_ack_n, chain_in, int_req_n, chain_out, vec_oe, ack_en, rd_d;
  logic [7:0]  vec_out;
  logic [3:0]  settle;
  logic [7:0]  b [4];
  logic [15:0] note;
  logic [15:0] exp_q [$];
  int          errors, n_compared;
  rx_int_ack_vector_logic #(.FIFO_DEPTH(8)) dut (
    .clk(clk), .srst(srst), .req(req), .rdata(rdata), .rx_in(rx_in), .tx_empty(tx_empty),
    .ext_change(ext_change), .int_ack_n(int_ack_n), .chain_in(chain_in),
    .int_req_n(int_req_n), .chain_out(chain_out), .vec_out(vec_out), .vec_oe(vec_oe));
  host_ack_model host (.clk(clk), .ack_en(ack_en), .settle(settle), .int_req_n(int_req_n),
    .int_ack_n(int_ack_n), .chain_in(chain_in));
  // ****************************************************************
  // bus tasks; each access leaves one idle edge so no strobe is set twice at once
  // ****************************************************************
  task automatic wr(input logic a, input logic [3:0] ad, input logic [7:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, chan_a: a, addr: ad, wdata: d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic a, input logic [3:0] ad, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e & m});
    req <= '{wr: 1'b0, rd: 1'b1, chan_a: a, addr: ad, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic push(input int ch, input logic [7:0] d, input logic [3:0] e);
    rx_in[ch] <= '{valid: 1'b1, data: d, err: e};
    @(posedge clk);
    rx_in[ch].valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_lvl(ref logic s, input logic lvl, input string nm);
    int i;
    i = 0;
    while (s !== lvl && i < 20) begin
      @(posedge clk);
      i++;
    end
    `CHK(nm, lvl, s)
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    tx_empty[1] <= 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************************************
  // read answers are checked mid-cycle, the only cycle they stand
  // ****************************************************************
  always @(posedge clk) rd_d <= req.rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      note = exp_q.pop_front();
      `CHK("rdata", note[7:0], rdata & note[15:8])
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial begin
    srst = 1'b1; req = '0; rx_in[0] = '0; rx_in[1] = '0; tx_empty[0] = 1'b0;
    tx_empty[1] = 1'b0; ext_change[0] = 1'b0; ext_change[1] = 1'b0; ack_en = 1'b0;
    settle = 4'h1; errors = 0; n_compared = 0;
    void'($urandom(7));
    for (int i = 0; i < 4; i++) b[i] = 8'($urandom);
    // polled vector with status in either field
    do_reset();
    ext_change[0] <= 1'($urandom);
    wr(1'b1, OFS_INT_ENABLE, 8'h02);
    wr(1'b0, OFS_MASTER_CTRL, 8'h10);
    tx_empty[1] <= 1'b1;
    repeat (4) @(posedge clk);
    rd(1'b0, OFS_VECTOR, 8'hFF, 8'h10);
    rd(1'b1, OFS_PENDING, 8'hFF, 8'h10);
    rd(1'b0, OFS_PENDING, 8'hFF, 8'h00);
    wr(1'b0, OFS_MASTER_CTRL, 8'h00);
    rd(1'b0, OFS_VECTOR, 8'hFF, 8'h08);
    `CHK("request without enable", 1'b1, int_req_n)
    wr(1'b0, OFS_MASTER_CTRL, 8'h08);
    wait_lvl(int_req_n, 1'b0, "tx request");
    tx_empty[1] <= 1'b0;
    wait_lvl(int_req_n, 1'b1, "tx cleared");
    $display("test polled vector done");
    // hardware acknowledge, with and then without a vector
    do_reset();
    wr(1'b0, OFS_VECTOR, 8'hA1);
    wr(1'b1, OFS_INT_ENABLE, 8'h02);
    wr(1'b0, OFS_MASTER_CTRL, 8'h09);
    tx_empty[1] <= 1'b1;
    wait_lvl(int_req_n, 1'b0, "request before ack");
    ack_en <= 1'b1;
    wait_lvl(vec_oe, 1'b1, "vector drive");
    ack_en <= 1'b0;
    `CHK("ack vector", 8'hA9, vec_out)
    repeat (8) @(posedge clk);
    `CHK("served request", 1'b1, int_req_n)
    `CHK("chain held", 1'b0, chain_out)
    wr(1'b0, OFS_COMMAND, 8'h38);
    wait_lvl(int_req_n, 1'b0, "request after service reset");
    wr(1'b0, OFS_MASTER_CTRL, 8'h0B);
    settle <= 4'h9;
    ack_en <= 1'b1;
    wait_lvl(int_ack_n, 1'b0, "slow ack");
    ack_en <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("no vector drive", 1'b0, vec_oe)
    rd(1'b0, OFS_VECTOR, 8'hFF, 8'hA9);
    $display("test hardware ack done");
    // software acknowledge through the vector read
    do_reset();
    wr(1'b0, OFS_VECTOR, 8'h5A);
    wr(1'b1, OFS_INT_ENABLE, 8'h02);
    wr(1'b0, OFS_MASTER_CTRL, 8'h2B);
    tx_empty[1] <= 1'b1;
    wait_lvl(int_req_n, 1'b0, "soft request");
    rd(1'b1, OFS_VECTOR, 8'hFF, 8'h5A);
    `CHK("soft ack request", 1'b1, int_req_n)
    `CHK("soft ack chain", 1'b0, chain_out)
    rd(1'b0, OFS_VECTOR, 8'hFF, 8'h58);
    $display("test software ack done");
    // every receive mode with one plain byte
    for (int m = 0; m < 4; m++) begin
      do_reset();
      wr(1'b0, OFS_INT_ENABLE, {3'h0, 2'(m), 3'h0});
      wr(1'b0, OFS_MASTER_CTRL, 8'h08);
      push(0, b[m], 4'h0);
      repeat (4) @(posedge clk);
      `CHK("mode request", (m == 1 || m == 2) ? 1'b0 : 1'b1, int_req_n)
    end
    $display("test receive modes done");
    // special only: the bad byte locks the exit slot until error reset
    do_reset();
    wr(1'b0, OFS_INT_ENABLE, 8'h18);
    wr(1'b0, OFS_MASTER_CTRL, 8'h08);
    push(0, b[1], 4'h4);
    push(0, b[2], 4'h0);
    rd(1'b0, OFS_RX_DATA, 8'hFF, b[1]);
    wait_lvl(int_req_n, 1'b0, "special locks");
    rd(1'b0, OFS_RX_DATA, 8'hFF, b[2]);
    wr(1'b0, OFS_COMMAND, 8'h30);
    wait_lvl(int_req_n, 1'b1, "error reset");
    rd(1'b0, OFS_RX_DATA, 8'hFF, b[2]);
    $display("test special lock done");
    // single byte, then four byte threshold and an early special condition
    do_reset();
    wr(1'b0, OFS_INT_ENABLE, 8'h10);
    wr(1'b0, OFS_MASTER_CTRL, 8'h08);
    rd(1'b0, OFS_MAIN_STATUS, 8'h01, 8'h00);
    push(0, b[0], 4'h0);
    wait_lvl(int_req_n, 1'b0, "one byte request");
    rd(1'b0, OFS_VECTOR, 8'hFF, 8'h04);
    rd(1'b0, OFS_RX_DATA, 8'hFF, b[0]);
    wait_lvl(int_req_n, 1'b1, "fifo empty");
    wr(1'b0, OFS_EXT_FEATURE, 8'h08);
    for (int i = 0; i < 3; i++) push(0, b[i], 4'h0);
    repeat (4) @(posedge clk);
    `CHK("below threshold", 1'b1, int_req_n)
    rd(1'b0, OFS_MAIN_STATUS, 8'h01, 8'h01);
    push(0, b[3], 4'h0);
    wait_lvl(int_req_n, 1'b0, "threshold request");
    wr(1'b0, OFS_MASTER_CTRL, 8'h28);
    rd(1'b0, OFS_VECTOR, 8'hFF, 8'h04);
    wait_lvl(int_req_n, 1'b1, "served threshold");
    wr(1'b0, OFS_COMMAND, 8'h38);
    wait_lvl(int_req_n, 1'b0, "four left after reset");
    rd(1'b0, OFS_RX_ERROR, 8'hF0, 8'h00);
    rd(1'b0, OFS_RX_DATA, 8'hFF, b[0]);
    wait_lvl(int_req_n, 1'b1, "under threshold");
    rd(1'b0, OFS_RX_DATA, 8'hFF, b[1]);
    push(0, 8'h3C, 4'h2);
    wait_lvl(int_req_n, 1'b0, "special at once");
    rd(1'b0, OFS_VECTOR, 8'hFF, 8'h06);
    $display("test receive threshold done");
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
bind rx_int_ack_vector_logic rx_int_ack_monitor mon (
  .clk(clk), .srst(srst), .req(req), .rdata(rdata), .int_ack_n(int_ack_n),
  .int_req_n(int_req_n), .chain_out(chain_out), .vec_out(vec_out), .vec_oe(vec_oe));
